/* File: hw/iodr_regs.sv */
// read-only output data registers: rate x/y/z and accel x
`timescale 1ns/10ps
`default_nettype none
module iodr_regs #(
  parameter int unsigned RATE_RANGE = 0
) (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic        sample_valid_i,
  input  wire logic [31:0] rate_x_sample_i,
  input  wire logic [31:0] rate_y_sample_i,
  input  wire logic [31:0] rate_z_sample_i,
  input  wire logic [31:0] accel_x_sample_i,
  input  wire logic        rd_en_i,
  input  wire logic [6:0]  rd_addr_i,
  output logic             rd_valid_o,
  output logic [15:0]      rd_data_o,
  output logic [31:0]      rate_step_o
);

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // saturate a signed 32-bit sample to the documented full scale
  function automatic logic [31:0] iodr_clamp(input logic [31:0] v,
                                             input logic [31:0] pos,
                                             input logic [31:0] neg);
    if ($signed(v) > $signed(pos))
      return pos;
    else if ($signed(v) < $signed(neg))
      return neg;
    else
      return v;
  endfunction

  logic [31:0] rate_x;
  logic [31:0] rate_y;
  logic [31:0] rate_z;
  logic [31:0] accel_x;
  logic [15:0] next_rd_data;

  // -----------------------------------------------------------------
  // sample capture
  // -----------------------------------------------------------------
  // one 32-bit register per axis, so high and low words are always
  // updated together from the same sample
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rate_x  <= iodr_pkg::DATA_RESET;
      rate_y  <= iodr_pkg::DATA_RESET;
      rate_z  <= iodr_pkg::DATA_RESET;
      accel_x <= iodr_pkg::DATA_RESET;
    end
    else if (sample_valid_i)
    begin
      rate_x  <= iodr_clamp(rate_x_sample_i, iodr_pkg::RATE_POS_FULL, iodr_pkg::RATE_NEG_FULL);
      rate_y  <= iodr_clamp(rate_y_sample_i, iodr_pkg::RATE_POS_FULL, iodr_pkg::RATE_NEG_FULL);
      rate_z  <= iodr_clamp(rate_z_sample_i, iodr_pkg::RATE_POS_FULL, iodr_pkg::RATE_NEG_FULL);
      accel_x <= iodr_clamp(accel_x_sample_i, iodr_pkg::ACCEL_POS_FULL,
                            iodr_pkg::ACCEL_NEG_FULL);
    end
  end

  // -----------------------------------------------------------------
  // read port
  // -----------------------------------------------------------------
  // both bytes of a word decode to the same register; writes do not exist
  always_comb
  begin
    unique case ({rd_addr_i[6:1], 1'b0})
      iodr_pkg::ADDR_RATE_X_FRACTION:  next_rd_data = rate_x[15:0];
      iodr_pkg::ADDR_RATE_X_INTEGER:   next_rd_data = rate_x[31:16];
      iodr_pkg::ADDR_RATE_Y_FRACTION:  next_rd_data = rate_y[15:0];
      iodr_pkg::ADDR_RATE_Y_INTEGER:   next_rd_data = rate_y[31:16];
      iodr_pkg::ADDR_RATE_Z_FRACTION:  next_rd_data = rate_z[15:0];
      iodr_pkg::ADDR_RATE_Z_INTEGER:   next_rd_data = rate_z[31:16];
      iodr_pkg::ADDR_ACCEL_X_FRACTION: next_rd_data = accel_x[15:0];
      iodr_pkg::ADDR_ACCEL_X_INTEGER:  next_rd_data = accel_x[31:16];
      default:                         next_rd_data = iodr_pkg::UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rd_valid_o <= 1'b0;
      rd_data_o  <= iodr_pkg::UNMAPPED_READ;
    end
    else
    begin
      rd_valid_o <= rd_en_i;
      if (rd_en_i)
        rd_data_o <= next_rd_data;
    end
  end

  // -----------------------------------------------------------------
  // range variant
  // -----------------------------------------------------------------
  // fixed per build; software uses it to scale the integer words
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      rate_step_o <= (RATE_RANGE == 2) ? iodr_pkg::RATE_STEP_RANGE2 :
                     (RATE_RANGE == 1) ? iodr_pkg::RATE_STEP_RANGE1 :
                                         iodr_pkg::RATE_STEP_RANGE0;
    else
      rate_step_o <= rate_step_o;
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_read_req(logic [6:0] a);
    rd_en_i && ({rd_addr_i[6:1], 1'b0} == a);
  endsequence

  // low then high word of z on consecutive cycles
  sequence s_z_pair;
    s_read_req(7'h0C) ##1 s_read_req(7'h0E);
  endsequence

  property p_rate_x_capture;
    sample_valid_i |=> rate_x == iodr_clamp($past(rate_x_sample_i),
      iodr_pkg::RATE_POS_FULL, iodr_pkg::RATE_NEG_FULL);
  endproperty
  a_rate_x_capture: assert property (p_rate_x_capture)
    else $error("rate x not captured from sample");

  property p_hold;
    !sample_valid_i |=> $stable(rate_x) && $stable(rate_y) && $stable(rate_z) && $stable(accel_x);
  endproperty
  a_hold: assert property (p_hold)
    else $error("data changed without a sample");

  property p_rate_range;
    $signed(rate_x) <= $signed(iodr_pkg::RATE_POS_FULL) &&
      $signed(rate_x) >= $signed(iodr_pkg::RATE_NEG_FULL) &&
      $signed(rate_y) <= $signed(iodr_pkg::RATE_POS_FULL) &&
      $signed(rate_y) >= $signed(iodr_pkg::RATE_NEG_FULL) &&
      $signed(rate_z) <= $signed(iodr_pkg::RATE_POS_FULL) &&
      $signed(rate_z) >= $signed(iodr_pkg::RATE_NEG_FULL);
  endproperty
  a_rate_range: assert property (p_rate_range)
    else $error("rate outside full scale");

  property p_accel_sat;
    sample_valid_i && $signed(accel_x_sample_i) > $signed(iodr_pkg::ACCEL_POS_FULL)
      |=> accel_x[31:16] == 16'h7D00;
  endproperty
  a_accel_sat: assert property (p_accel_sat)
    else $error("accel not saturated to full scale");

  property p_read_x_int;
    s_read_req(7'h06) |=> rd_valid_o && rd_data_o == $past(rate_x[31:16]);
  endproperty
  a_read_x_int: assert property (p_read_x_int)
    else $error("rate x high word read wrong");

  property p_read_y_frac;
    s_read_req(7'h08) |=> rd_data_o == $past(rate_y[15:0]);
  endproperty
  a_read_y_frac: assert property (p_read_y_frac)
    else $error("rate y low word read wrong");

  property p_read_odd_byte;
    rd_en_i && rd_addr_i == 7'h0B |=> rd_data_o == $past(rate_y[31:16]);
  endproperty
  a_read_odd_byte: assert property (p_read_odd_byte)
    else $error("odd byte of rate y high word read wrong");

  property p_read_z;
    s_z_pair |=> {rd_data_o, $past(rd_data_o)} == $past(rate_z, 2)
      || $past(sample_valid_i, 2);
  endproperty
  a_read_z: assert property (p_read_z)
    else $error("rate z words incoherent");

  property p_read_accel_lo;
    s_read_req(7'h10) |=> rd_data_o == $past(accel_x[15:0]);
  endproperty
  a_read_accel_lo: assert property (p_read_accel_lo)
    else $error("accel x low word read wrong");

  property p_unmapped;
    rd_en_i && rd_addr_i > 7'h13 |=> rd_valid_o && rd_data_o == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_valid_pulse;
    !rd_en_i |=> !rd_valid_o;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("read valid without request");

  property p_accel_neg_sat;
    sample_valid_i && $signed(accel_x_sample_i) < $signed(iodr_pkg::ACCEL_NEG_FULL)
      |=> accel_x[31:16] == 16'h8300;
  endproperty
  a_accel_neg_sat: assert property (p_accel_neg_sat)
    else $error("accel not saturated to negative full scale");

  property p_rate_yz_capture;
    sample_valid_i |=>
      rate_y == iodr_clamp($past(rate_y_sample_i), iodr_pkg::RATE_POS_FULL,
                           iodr_pkg::RATE_NEG_FULL) &&
      rate_z == iodr_clamp($past(rate_z_sample_i), iodr_pkg::RATE_POS_FULL,
                           iodr_pkg::RATE_NEG_FULL);
  endproperty
  a_rate_yz_capture: assert property (p_rate_yz_capture)
    else $error("rate y or z not captured from sample");

  property p_read_valid;
    rd_en_i |=> rd_valid_o;
  endproperty
  a_read_valid: assert property (p_read_valid)
    else $error("read not answered in one cycle");

  property p_read_x_frac;
    s_read_req(7'h04) |=> rd_data_o == $past(rate_x[15:0]);
  endproperty
  a_read_x_frac: assert property (p_read_x_frac)
    else $error("rate x low word read wrong");

  property p_read_accel_int;
    s_read_req(7'h12) |=> rd_data_o == $past(accel_x[31:16]);
  endproperty
  a_read_accel_int: assert property (p_read_accel_int)
    else $error("accel x high word read wrong");

endmodule
`default_nettype wire

/* File: hw/iodr_pkg.sv */
// constants for the inertial output data register set
// Notes on behaviour
// - rate x high word: signed, one count per step
// - rate x low word adds fractional bits
// - rate x low 0x04/05, high 0x06/07, read-only
// - rate y high word at 0x0A/0x0B, read-only
// - rate y low word at 0x08/0x09, read-only
// - rate z low 0x0C/0D, high 0x0E/0F, read-only
// - rate full scale 0x4E20, minus 0xB1E0
// - combined rate full scale 0x4E200000 / 0xB1E00000
// - acceleration is 32-bit pair of words
// - accel full scale 0x7D00, minus 0x8300
// - combined accel full scale 0x7D000000 / 0x83000000
// - accel x low word at 0x10/0x11, read-only
// - rate step depends on range variant
// - accel x high word at 0x12/0x13, read-only
`default_nettype none
package iodr_pkg;
  // -----------------------------------------------------------------
  // register byte addresses (word index is address bit 6..1)
  // -----------------------------------------------------------------
  localparam logic [6:0] ADDR_RATE_X_FRACTION = 7'h04;
  localparam logic [6:0] ADDR_RATE_X_INTEGER  = 7'h06;
  localparam logic [6:0] ADDR_RATE_Y_FRACTION = 7'h08;
  localparam logic [6:0] ADDR_RATE_Y_INTEGER  = 7'h0A;
  localparam logic [6:0] ADDR_RATE_Z_FRACTION = 7'h0C;
  localparam logic [6:0] ADDR_RATE_Z_INTEGER  = 7'h0E;
  localparam logic [6:0] ADDR_ACCEL_X_FRACTION = 7'h10;
  localparam logic [6:0] ADDR_ACCEL_X_INTEGER  = 7'h12;
  // -----------------------------------------------------------------
  // full-scale limits of the combined 32-bit words
  // -----------------------------------------------------------------
  localparam logic [31:0] RATE_POS_FULL  = 32'h4E200000;
  localparam logic [31:0] RATE_NEG_FULL  = 32'hB1E00000;
  localparam logic [31:0] ACCEL_POS_FULL = 32'h7D000000;
  localparam logic [31:0] ACCEL_NEG_FULL = 32'h83000000;
  // -----------------------------------------------------------------
  // rate step per high-word count, in micro degrees per second
  // -----------------------------------------------------------------
  localparam logic [31:0] RATE_STEP_RANGE0 = 32'h0000186A; // 6250
  localparam logic [31:0] RATE_STEP_RANGE1 = 32'h000061A8; // 25000
  localparam logic [31:0] RATE_STEP_RANGE2 = 32'h000186A0; // 100000
  // reset value of every data word
  localparam logic [31:0] DATA_RESET = 32'h00000000;
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;
endpackage
`default_nettype wire

/* File: testbench/iodr_host_model.sv */
// host model issuing word reads on the register read port
`timescale 1ns/10ps
`default_nettype none
module iodr_host_model (
  input  wire logic        sys_clk_i,
  input  wire logic        rd_valid_i,
  input  wire logic [15:0] rd_data_i,
  output logic             rd_en_o,
  output logic [6:0]       rd_addr_o
);
  initial
  begin
    rd_en_o   = 1'b0;
    rd_addr_o = 7'h7F;
  end
  // request held up to its taking edge; answer stands one cycle, taken at once
  task automatic read_word(input logic [6:0] a, output logic ok, output logic [15:0] d);
    @(posedge sys_clk_i);
    #1;
    rd_en_o   = 1'b1;
    rd_addr_o = a;
    @(posedge sys_clk_i);
    #1;
    rd_en_o   = 1'b0;
    rd_addr_o = ~a;
    ok        = rd_valid_i;
    d         = rd_data_i;
  endtask
  // two words back to back at a and a+2; enable stays up between them
  task automatic read_pair(input logic [6:0] a, output logic [1:0] ok, output logic [31:0] d);
    @(posedge sys_clk_i);
    #1;
    rd_en_o   = 1'b1;
    rd_addr_o = a;
    @(posedge sys_clk_i);
    #1;
    rd_addr_o = a + 7'h02;
    ok[0]     = rd_valid_i;
    d[15:0]   = rd_data_i;
    @(posedge sys_clk_i);
    #1;
    rd_en_o   = 1'b0;
    rd_addr_o = ~a;
    ok[1]     = rd_valid_i;
    d[31:16]  = rd_data_i;
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb_inertial_output_data_registers.sv */
// self-checking bench for the inertial output data registers
`timescale 1ns/10ps
`default_nettype none
module tb_inertial_output_data_registers;
  logic        sys_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        sample_valid_i = 1'b0;
  logic [31:0] smp [4] = '{32'h0, 32'h0, 32'h0, 32'h0};
  logic        rd_en;
  logic [6:0]  rd_addr;
  logic        rd_valid;
  logic [15:0] rd_data;
  logic [31:0] rate_step;
  int          failures = 0;
  int          check_count = 0;
  int          cycles = 0;
  // last two sets hold values past full scale to exercise saturation both ways
  logic [31:0] sets [4][4] = '{
    '{32'h4E200000, 32'hB1E00000, 32'hFFFFFFFF, 32'h83000000},
    '{32'h00010002, 32'hFFFE0000, 32'h00000001, 32'h7D000000},
    '{32'h7FFFFFFF, 32'h80000000, 32'hB1DFFFFF, 32'h7D000001},
    '{32'h4E200001, 32'hB1E00001, 32'h0000FFFF, 32'h82FFFFFF}};
  logic [31:0] exps [4][4] = '{
    '{32'h4E200000, 32'hB1E00000, 32'hFFFFFFFF, 32'h83000000},
    '{32'h00010002, 32'hFFFE0000, 32'h00000001, 32'h7D000000},
    '{32'h4E200000, 32'hB1E00000, 32'hB1E00000, 32'h7D000000},
    '{32'h4E200000, 32'hB1E00001, 32'h0000FFFF, 32'h83000000}};
  iodr_regs #(.RATE_RANGE(1)) u_iodr_regs (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .sample_valid_i(sample_valid_i), .rate_x_sample_i(smp[0]), .rate_y_sample_i(smp[1]),
    .rate_z_sample_i(smp[2]), .accel_x_sample_i(smp[3]), .rd_en_i(rd_en),
    .rd_addr_i(rd_addr), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .rate_step_o(rate_step));
  iodr_host_model u_iodr_host_model (.sys_clk_i(sys_clk_i), .rd_valid_i(rd_valid),
    .rd_data_i(rd_data), .rd_en_o(rd_en), .rd_addr_o(rd_addr));
  always #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      failures++;
      final_report();
    end
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic read_chk(input logic [6:0] a, input logic [15:0] e);
    logic        ok;
    logic [15:0] d;
    u_iodr_host_model.read_word(a, ok, d);
    check({31'h0, ok}, 32'h1);
    check({16'h0, d}, {16'h0, e});
  endtask
  task automatic read_z_chk(input logic [31:0] e);
    logic [1:0]  ok;
    logic [31:0] d;
    u_iodr_host_model.read_pair(7'h0C, ok, d);
    check({30'h0, ok}, 32'h3);
    check(d, e);
  endtask
  // odd byte of each word is used for the high words: both bytes give the word
  task automatic read_all(input logic [31:0] e [4]);
    for (int i = 0; i < 8; i++)
    begin
      read_chk(7'h04 + 7'(2 * i) + 7'(i % 2), (i % 2) ? e[i / 2][31:16] : e[i / 2][15:0]);
    end
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    logic [31:0] e [4];
    repeat (3) @(posedge sys_clk_i);
    #1;
    reset_i = 1'b0;
    check(rate_step, 32'h000061A8);
    e = '{32'h0, 32'h0, 32'h0, 32'h0};
    read_all(e);
    $display("test reset done");
    for (int s = 0; s < 4; s++)
    begin
      @(posedge sys_clk_i);
      #1;
      smp = sets[s];
      sample_valid_i = 1'b1;
      @(posedge sys_clk_i);
      #1;
      sample_valid_i = 1'b0;
      smp = '{32'h0, 32'h0, 32'h0, 32'h0};
      e = exps[s];
      read_all(e);
      read_z_chk(e[2]);
      $display("test sample set %0d done", s);
    end
    @(posedge sys_clk_i);
    #1;
    reset_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    reset_i = 1'b0;
    e = '{32'h0, 32'h0, 32'h0, 32'h0};
    read_all(e);
    check(rate_step, 32'h000061A8);
    $display("test second reset done");
    read_chk(7'h02, 16'h0000);
    read_chk(7'h14, 16'h0000);
    $display("test unmapped done");
    final_report();
  end
endmodule
`default_nettype wire
